// ==== can_tx_buffer_and_filter_ctl_tb_top.sv ====
// Self-checking bench for the CAN transmit and filter control block
`timescale 1ns/1ps
`include "cbf_consts.vh"
module can_tx_buffer_and_filter_ctl_tb_top;
  typedef struct packed {
    logic        we;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0]  s;
  } cbf_row_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  rs;
  wire         awready, wready, bvalid, arready, rvalid, tx_irq, closed, init_ack, rx_shift;
  wire [1:0]   bresp, rresp, mode, rbuf, rword;
  wire [31:0]  rdata, eng_data;
  wire [2:0]   done, active, fail, pend, hit;
  int          error_cnt, n_compared, cyc, i;
  cbf_row_t    rows [10];

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  cbf_ctl #(.NBUF(3)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_done(done), .tx_active(active), .tx_fail(fail), .rx_shift(rx_shift),
    .rx_hit_index(hit), .eng_rd_buf(rbuf), .eng_rd_word(rword), .eng_rd_data(eng_data),
    .tx_pending(pend), .tx_irq(tx_irq), .acceptance_mode(mode), .rx_filter_closed(closed),
    .init_acknowledge(init_ack)
  );
  cbf_eng_model eng_u (
    .aclk(aclk), .tx_pending(pend), .tx_done(done), .tx_active(active), .tx_fail(fail),
    .rx_shift(rx_shift), .rx_hit_index(hit), .eng_rd_buf(rbuf), .eng_rd_word(rword)
  );

  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task rdt(input [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task rchk(input [7:0] a, input [31:0] q);
    rdt(a);
    chk("read data", rd, q);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("[FAIL] run length expected 4999 seen %0d", cyc);
      report_and_stop();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    rows[0] = '{1'b0, 8'h00, 32'h0, 32'h7, 2'h0};
    rows[1] = '{1'b1, 8'h44, 32'h1, 32'h0, 2'h2};
    rows[2] = '{1'b1, 8'h04, 32'hff, 32'h7, 2'h0};
    rows[3] = '{1'b1, 8'h0c, 32'h7, 32'h0, 2'h0};
    rows[4] = '{1'b1, 8'h10, 32'h6, 32'h2, 2'h0};
    rows[5] = '{1'b1, 8'h10, 32'h3, 32'h1, 2'h0};
    rows[6] = '{1'b1, 8'h14, 32'h3, 32'h0, 2'h0};
    rows[7] = '{1'b1, 8'h20, 32'hff, 32'h0, 2'h0};
    rows[8] = '{1'b1, 8'h40, 32'hcafe0001, 32'hcafe0001, 2'h0};
    rows[9] = '{1'b0, 8'h50, 32'h0, 32'h0, 2'h2};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 10; i++) begin
      if (rows[i].we) begin
        wr(rows[i].a, rows[i].d);
        chk("row wresp", rs, rows[i].s);
      end
      rdt(rows[i].a);
      chk("row data", rd, rows[i].q);
      chk("row resp", rs, rows[i].s);
    end
    $display("Register table test done");
    wr(8'h18, 32'h1);
    @(posedge aclk);
    chk("init ack", init_ack, 32'h1);
    rchk(8'h1c, 32'h1);
    rchk(8'h04, 32'h0);
    wr(8'h04, 32'h7);
    rchk(8'h04, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(8'h14, i);
      @(posedge aclk);
      chk("mode", mode, i);
    end
    chk("closed", closed, 32'h1);
    wr(8'h18, 32'h0);
    eng_u.rx(3'h6);
    rchk(8'h14, 32'h3);
    wr(8'h18, 32'h1);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    eng_u.rx(3'h5);
    rchk(8'h14, 32'h50);
    eng_u.rx(3'h2);
    rchk(8'h14, 32'h20);
    $display("Init and filter test done");
    wr(8'h04, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h40, 32'h5a5a1234);
    repeat (2) @(posedge aclk);
    chk("engine read", eng_data, 32'h5a5a1234);
    chk("irq", tx_irq, 32'h1);
    wr(8'h00, 32'h1);
    rchk(8'h00, 32'h6);
    chk("irq", tx_irq, 32'h0);
    rdt(8'h40);
    chk("blocked resp", rs, 32'h2);
    wr(8'h40, 32'h0);
    chk("blocked wresp", rs, 32'h2);
    chk("engine read", eng_data, 32'h5a5a1234);
    eng_u.send(0, 1'b0);
    repeat (3) @(posedge aclk);
    rchk(8'h00, 32'h7);
    rchk(8'h0c, 32'h0);
    $display("Transmit test done");
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h1);
    rchk(8'h0c, 32'h1);
    rchk(8'h00, 32'h7);
    rchk(8'h08, 32'h0);
    chk("irq", tx_irq, 32'h1);
    wr(8'h00, 32'h1);
    rchk(8'h0c, 32'h0);
    fork
      eng_u.send(0, 1'b1);
      begin
        wait (active[0]);
        wr(8'h08, 32'h1);
        wr(8'h08, 32'h0);
        rchk(8'h08, 32'h1);
      end
    join
    repeat (2) @(posedge aclk);
    rchk(8'h0c, 32'h1);
    rchk(8'h00, 32'h7);
    $display("Abort test done");
    // Schedule buffer 1 first so the forced-off pending output is visible
    wr(8'h00, 32'h2);
    wr(8'h18, 32'h2);
    wr(8'h00, 32'h1);
    rchk(8'h00, 32'h5);
    chk("pending", pend, 32'h0);
    wr(8'h18, 32'h0);
    repeat (2) @(posedge aclk);
    chk("pending", pend, 32'h2);
    $display("Listen test done");
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk("pending", pend, 32'h0);
    chk("irq", tx_irq, 32'h0);
    rchk(8'h00, 32'h7);
    rchk(8'h04, 32'h0);
    rchk(8'h10, 32'h0);
    rchk(8'h14, 32'h0);
    $display("Reset test done");
    report_and_stop();
  end
endmodule // can_tx_buffer_and_filter_ctl_tb_top

// ==== cbf_consts.vh ====
// Register map, field layout and reset values for the CAN transmit/filter control block
`ifndef CBF_CONSTS_VH
`define CBF_CONSTS_VH

`define CBF_ADDR_W        8
`define CBF_NBUF          3

// Register byte offsets
`define CBF_OFS_TFLG      8'h00
`define CBF_OFS_TIER      8'h04
`define CBF_OFS_TARQ      8'h08
`define CBF_OFS_TAAK      8'h0c
`define CBF_OFS_TBSEL     8'h10
`define CBF_OFS_IDAC      8'h14
`define CBF_OFS_CTL       8'h18
`define CBF_OFS_STAT      8'h1c
`define CBF_OFS_RSV_LO    8'h20
`define CBF_OFS_RSV_HI    8'h3c
`define CBF_OFS_WIN_LO    8'h40
`define CBF_OFS_WIN_HI    8'h4c

// Transmit buffer window geometry
`define CBF_WIN_WORDS     4
`define CBF_WORD_W        2
`define CBF_MEM_DEPTH     12

// Field positions
`define CBF_IDAC_MODE_LSB 0
`define CBF_IDAC_MODE_MSB 1
`define CBF_IDAC_HIT_LSB  4
`define CBF_IDAC_HIT_MSB  6
`define CBF_CTL_INIT_BIT  0
`define CBF_CTL_LISTEN    1
`define CBF_STAT_INIT_ACKNOWLEDGE   0

// Reset values and the closed mode encoding
`define CBF_RST_EMPTY     3'h7
`define CBF_RST_ZERO3     3'h0
`define CBF_RST_MODE      2'h0
`define CBF_MODE_CLOSED   2'h3

// AXI responses
`define CBF_RESP_OKAY     2'h0
`define CBF_RESP_SLVERR   2'h2

`endif

// ==== cbf_ctl.v ====
// CAN transmit buffer flags, abort handling, buffer window and acceptance control
//
// Contract
// - Init mode holds transmit registers in reset
// - Writing one clears empty flag, zero ignored
// - Successful transmission sets empty flag
// - Granted abort sets empty flag
// - Irq while any enabled empty flag set
// - Clearing empty also clears abort acknowledge
// - Empty flag set clears abort request
// - Listen mode: no clear, no transmission
// - Scheduled buffer blocks window reads and writes
// - Grant abort if unstarted or failed
// - Granted abort sets empty and acknowledge
// - Software only sets abort requests
// - Abort acknowledge read-only, set on abort
// - Lowest set select bit picks window buffer
// - Select reads back lowest set bit only
// - No selection refuses window accesses
// - Acceptance control written only in init
// - Mode field: 2x32, 4x16, 8x8, closed
// - Closed mode accepts no message
// - Hit index is three-bit filter number
// - Hit index tracks foreground buffer message
// - Reserved test registers read zero, ignore writes
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cbf_consts.vh"
module cbf_ctl #(
  parameter NBUF = `CBF_NBUF
) (
  input  wire                   aclk,
  input  wire                   aresetn,
  input  wire [`CBF_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output wire [1:0]             s_axi_bresp,
  output wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`CBF_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output wire [31:0]            s_axi_rdata,
  output wire [1:0]             s_axi_rresp,
  output wire                   s_axi_rvalid,
  input  wire                   s_axi_rready,
  input  wire [NBUF-1:0]        tx_done,
  input  wire [NBUF-1:0]        tx_active,
  input  wire [NBUF-1:0]        tx_fail,
  input  wire                   rx_shift,
  input  wire [2:0]             rx_hit_index,
  input  wire [1:0]             eng_rd_buf,
  input  wire [`CBF_WORD_W-1:0] eng_rd_word,
  output wire [31:0]            eng_rd_data,
  output wire [NBUF-1:0]        tx_pending,
  output wire                   tx_irq,
  output wire [1:0]             acceptance_mode,
  output wire                   rx_filter_closed,
  output wire                   init_acknowledge
);

  // Window address decode, shared by the read and write paths
  function is_win;
    input [`CBF_ADDR_W-1:0] a;
    begin
      is_win = (a >= `CBF_OFS_WIN_LO) && (a <= `CBF_OFS_WIN_HI);
    end
  endfunction

  // AXI state
  reg                   awready_reg;
  reg                   wready_reg;
  reg                   aw_have_reg;
  reg                   w_have_reg;
  reg [`CBF_ADDR_W-1:0] waddr_reg;
  reg [31:0]            wdata_reg;
  reg [3:0]             wstrb_reg;
  reg                   bvalid_reg;
  reg [1:0]             bresp_reg;
  reg                   arready_reg;
  reg                   rvalid_reg;
  reg [31:0]            rdata_reg;
  reg [1:0]             rresp_reg;

  // Control state
  reg [NBUF-1:0]        empty_reg;
  reg [NBUF-1:0]        empty_next;
  reg [NBUF-1:0]        ier_reg;
  reg [NBUF-1:0]        ier_next;
  reg [NBUF-1:0]        abreq_reg;
  reg [NBUF-1:0]        abreq_next;
  reg [NBUF-1:0]        abak_reg;
  reg [NBUF-1:0]        abak_next;
  reg [NBUF-1:0]        bsel_reg;
  reg [NBUF-1:0]        bsel_next;
  reg [1:0]             mode_reg;
  reg [2:0]             hit_reg;
  reg                   init_req_reg;
  reg                   init_ack_reg;
  reg                   listen_reg;
  reg                   tx_irq_reg;
  reg [NBUF-1:0]        tx_pending_reg;
  reg                   closed_reg;
  reg [31:0]            eng_rd_data_reg;
  reg [31:0]            mem [0:`CBF_MEM_DEPTH-1];

  wire [NBUF-1:0]       sel_onehot;
  wire [1:0]            sel_idx;
  wire                  sel_any;

  cbf_lowbit #(
    .N (NBUF)
  ) u_lowbit (
    .vec    (bsel_reg),
    .onehot (sel_onehot),
    .index  (sel_idx),
    .any    (sel_any)
  );

  wire init_active = init_req_reg & init_ack_reg;
  // Writes resume only after request and acknowledge have both dropped
  wire tx_wr_ok    = ~init_req_reg & ~init_ack_reg;
  wire do_wr       = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire wr_lo       = do_wr & wstrb_reg[0];
  wire [NBUF-1:0] wbits = wdata_reg[NBUF-1:0];

  // Window is usable only with a selection and an unscheduled buffer
  wire win_ok = sel_any & empty_reg[sel_idx];
  wire [3:0] win_index = {sel_idx, 2'h0} + {2'h0, waddr_reg[`CBF_WORD_W+1:2]};
  wire [3:0] win_rindex = {sel_idx, 2'h0} + {2'h0, s_axi_araddr[`CBF_WORD_W+1:2]};

  // Abort grant: not yet on the bus, or the attempt just failed
  wire [NBUF-1:0] grant  = abreq_reg & ~empty_reg & (~tx_active | tx_fail);
  wire [NBUF-1:0] set_e  = tx_done | grant;
  wire            wr_tflg = wr_lo & tx_wr_ok & (waddr_reg == `CBF_OFS_TFLG);
  // Listen mode refuses clearing so nothing gets scheduled
  wire [NBUF-1:0] sw_clr = (wr_tflg & ~listen_reg) ? (wbits & empty_reg) : {NBUF{1'b0}};

  always @* begin
    empty_next = empty_reg;
    ier_next   = ier_reg;
    abreq_next = abreq_reg;
    abak_next  = abak_reg;
    bsel_next  = bsel_reg;
    if (init_active) begin
      empty_next = `CBF_RST_EMPTY;
      ier_next   = `CBF_RST_ZERO3;
      abreq_next = `CBF_RST_ZERO3;
      abak_next  = `CBF_RST_ZERO3;
      bsel_next  = `CBF_RST_ZERO3;
    end else begin
      // Hardware set wins over a software clear in the same cycle
      empty_next = (empty_reg & ~sw_clr) | set_e;
      abak_next  = (abak_reg & ~sw_clr) | grant;
      abreq_next = abreq_reg & ~set_e;
      if (wr_lo && tx_wr_ok && (waddr_reg == `CBF_OFS_TARQ)) begin
        // Only scheduled buffers take a request; zeros never clear
        abreq_next = (abreq_reg | (wbits & ~empty_reg)) & ~set_e;
      end
      if (wr_lo && tx_wr_ok && (waddr_reg == `CBF_OFS_TIER)) begin
        ier_next = wbits;
      end
      if (wr_lo && tx_wr_ok && (waddr_reg == `CBF_OFS_TBSEL)) begin
        bsel_next = wbits;
      end
    end
  end

  // Write response code
  reg [1:0] wr_resp;
  always @* begin
    wr_resp = `CBF_RESP_OKAY;
    if (is_win(waddr_reg)) begin
      if (!win_ok) begin
        wr_resp = `CBF_RESP_SLVERR;
      end
    end else if (waddr_reg[1:0] != 2'h0) begin
      wr_resp = `CBF_RESP_SLVERR;
    end else if (waddr_reg > `CBF_OFS_RSV_HI) begin
      wr_resp = `CBF_RESP_SLVERR;
    end
  end

  // Read decode
  reg [31:0] rd_val;
  reg [1:0]  rd_resp;
  always @* begin
    rd_val  = 32'h0;
    rd_resp = `CBF_RESP_OKAY;
    if (s_axi_araddr == `CBF_OFS_TFLG) begin
      rd_val[NBUF-1:0] = empty_reg;
    end else if (s_axi_araddr == `CBF_OFS_TIER) begin
      rd_val[NBUF-1:0] = ier_reg;
    end else if (s_axi_araddr == `CBF_OFS_TARQ) begin
      rd_val[NBUF-1:0] = abreq_reg;
    end else if (s_axi_araddr == `CBF_OFS_TAAK) begin
      rd_val[NBUF-1:0] = abak_reg;
    end else if (s_axi_araddr == `CBF_OFS_TBSEL) begin
      rd_val[NBUF-1:0] = sel_onehot;
    end else if (s_axi_araddr == `CBF_OFS_IDAC) begin
      rd_val[`CBF_IDAC_MODE_MSB:`CBF_IDAC_MODE_LSB] = mode_reg;
      rd_val[`CBF_IDAC_HIT_MSB:`CBF_IDAC_HIT_LSB]   = hit_reg;
    end else if (s_axi_araddr == `CBF_OFS_CTL) begin
      rd_val[`CBF_CTL_INIT_BIT] = init_req_reg;
      rd_val[`CBF_CTL_LISTEN]   = listen_reg;
    end else if (s_axi_araddr == `CBF_OFS_STAT) begin
      rd_val[`CBF_STAT_INIT_ACKNOWLEDGE] = init_ack_reg;
    end else if ((s_axi_araddr >= `CBF_OFS_RSV_LO) && (s_axi_araddr <= `CBF_OFS_RSV_HI)) begin
      rd_val = 32'h0;
    end else if (is_win(s_axi_araddr)) begin
      if (win_ok) begin
        rd_val = mem[win_rindex];
      end else begin
        rd_resp = `CBF_RESP_SLVERR;
      end
    end else begin
      rd_resp = `CBF_RESP_SLVERR;
    end
  end

  // AXI write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      waddr_reg   <= {`CBF_ADDR_W{1'b0}};
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `CBF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        aw_have_reg <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_resp;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // AXI read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `CBF_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_val;
        rresp_reg   <= rd_resp;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // Transmit control registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      empty_reg <= `CBF_RST_EMPTY;
      ier_reg   <= `CBF_RST_ZERO3;
      abreq_reg <= `CBF_RST_ZERO3;
      abak_reg  <= `CBF_RST_ZERO3;
      bsel_reg  <= `CBF_RST_ZERO3;
    end else begin
      empty_reg <= empty_next;
      ier_reg   <= ier_next;
      abreq_reg <= abreq_next;
      abak_reg  <= abak_next;
      bsel_reg  <= bsel_next;
    end
  end

  // Mode control and outputs to the protocol engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      init_req_reg   <= 1'b0;
      init_ack_reg   <= 1'b0;
      listen_reg     <= 1'b0;
      mode_reg       <= `CBF_RST_MODE;
      hit_reg        <= `CBF_RST_ZERO3;
      tx_irq_reg     <= 1'b0;
      tx_pending_reg <= {NBUF{1'b0}};
      closed_reg     <= 1'b0;
    end else begin
      if (wr_lo && (waddr_reg == `CBF_OFS_CTL)) begin
        init_req_reg <= wdata_reg[`CBF_CTL_INIT_BIT];
        listen_reg   <= wdata_reg[`CBF_CTL_LISTEN];
      end
      // Acknowledge trails the request by one cycle
      init_ack_reg <= init_req_reg;
      if (wr_lo && init_active && (waddr_reg == `CBF_OFS_IDAC)) begin
        mode_reg <= wdata_reg[`CBF_IDAC_MODE_MSB:`CBF_IDAC_MODE_LSB];
      end
      // Closed filter never reloads the foreground buffer
      if (rx_shift && (mode_reg != `CBF_MODE_CLOSED)) begin
        hit_reg <= rx_hit_index;
      end
      tx_irq_reg     <= |(empty_next & ier_next);
      tx_pending_reg <= (listen_reg || init_active) ? {NBUF{1'b0}} : ~empty_reg;
      closed_reg     <= (mode_reg == `CBF_MODE_CLOSED);
    end
  end

  // Buffer storage: software fills through the window, engine reads
  always @(posedge aclk) begin
    if (do_wr && is_win(waddr_reg) && win_ok) begin
      if (wstrb_reg[0]) begin
        mem[win_index][7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        mem[win_index][15:8] <= wdata_reg[15:8];
      end
      if (wstrb_reg[2]) begin
        mem[win_index][23:16] <= wdata_reg[23:16];
      end
      if (wstrb_reg[3]) begin
        mem[win_index][31:24] <= wdata_reg[31:24];
      end
    end
  end

  wire [3:0] eng_index = {eng_rd_buf, 2'h0} + {2'h0, eng_rd_word};

  always @(posedge aclk) begin
    if (!aresetn) begin
      eng_rd_data_reg <= 32'h0;
    end else if (eng_rd_buf < NBUF) begin
      eng_rd_data_reg <= mem[eng_index];
    end else begin
      eng_rd_data_reg <= 32'h0;
    end
  end

  assign s_axi_awready    = awready_reg;
  assign s_axi_wready     = wready_reg;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = arready_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rdata      = rdata_reg;
  assign s_axi_rresp      = rresp_reg;
  assign tx_irq           = tx_irq_reg;
  assign tx_pending       = tx_pending_reg;
  assign acceptance_mode  = mode_reg;
  assign rx_filter_closed = closed_reg;
  assign init_acknowledge = init_ack_reg;
  assign eng_rd_data      = eng_rd_data_reg;

endmodule // cbf_ctl

// ==== cbf_ctl_monitor.sv ====
// Port-level assertions for the CAN transmit and filter control block
`timescale 1ns/1ps
`include "cbf_consts.vh"
module cbf_ctl_monitor #(
  parameter NBUF = 3
) (
  input wire                   aclk,
  input wire                   aresetn,
  input wire [`CBF_ADDR_W-1:0] s_axi_araddr,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_arready,
  input wire [31:0]            s_axi_rdata,
  input wire [1:0]             s_axi_rresp,
  input wire [NBUF-1:0]        tx_done,
  input wire [NBUF-1:0]        tx_pending,
  input wire [1:0]             acceptance_mode,
  input wire                   rx_filter_closed,
  input wire                   init_acknowledge
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire rd_take = s_axi_arvalid && s_axi_arready;

  property p_init_hold;
    init_acknowledge && $past(init_acknowledge) |-> tx_pending == 0;
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("transmit pending while in init mode");
  // Pending follows the flag one edge late, so the drop is seen two edges on
  property p_done_empty;
    tx_done[0] |-> ##2 !tx_pending[0];
  endproperty
  a_done_empty: assert property (p_done_empty)
    else $error("buffer still pending after done");
  property p_closed;
    acceptance_mode == `CBF_MODE_CLOSED |=> rx_filter_closed;
  endproperty
  a_closed: assert property (p_closed)
    else $error("closed mode not flagged");
  property p_open;
    acceptance_mode != `CBF_MODE_CLOSED |=> !rx_filter_closed;
  endproperty
  a_open: assert property (p_open)
    else $error("filter closed in an open mode");
  property p_rsv;
    rd_take && s_axi_araddr >= 8'h20 && s_axi_araddr <= 8'h3c && s_axi_araddr[1:0] == 2'h0
      |=> s_axi_rdata == 32'h0 && s_axi_rresp == `CBF_RESP_OKAY;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved read not zero");
  property p_sel;
    rd_take && s_axi_araddr == `CBF_OFS_TBSEL |=> $onehot0(s_axi_rdata);
  endproperty
  a_sel: assert property (p_sel)
    else $error("select read has several bits");
  property p_width;
    rd_take && s_axi_araddr <= `CBF_OFS_TBSEL && s_axi_araddr[1:0] == 2'h0
      |=> s_axi_rdata[31:3] == 29'h0;
  endproperty
  a_width: assert property (p_width)
    else $error("transmit register upper bits set");
  property p_idac;
    rd_take && s_axi_araddr == `CBF_OFS_IDAC |=> s_axi_rdata[31:7] == 25'h0 &&
      s_axi_rdata[3:2] == 2'h0;
  endproperty
  a_idac: assert property (p_idac)
    else $error("acceptance control unused bits set");
  property p_mode_init;
    $changed(acceptance_mode) |-> $past(init_acknowledge) || $past(init_acknowledge, 2);
  endproperty
  a_mode_init: assert property (p_mode_init)
    else $error("mode changed outside init mode");
endmodule // cbf_ctl_monitor

bind cbf_ctl cbf_ctl_monitor #(.NBUF(NBUF)) mon_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .tx_done(tx_done), .tx_pending(tx_pending),
  .acceptance_mode(acceptance_mode), .rx_filter_closed(rx_filter_closed),
  .init_acknowledge(init_acknowledge)
);

// ==== cbf_eng_model.sv ====
// Behavioural CAN engine standing beyond the transmit buffers
`timescale 1ns/1ps
module cbf_eng_model (
  input  wire       aclk,
  input  wire [2:0] tx_pending,
  output reg  [2:0] tx_done,
  output reg  [2:0] tx_active,
  output reg  [2:0] tx_fail,
  output reg        rx_shift,
  output reg  [2:0] rx_hit_index,
  output reg  [1:0] eng_rd_buf,
  output reg  [1:0] eng_rd_word
);
  initial begin
    tx_done = 3'h0;
    tx_active = 3'h0;
    tx_fail = 3'h0;
    rx_shift = 1'b0;
    rx_hit_index = 3'h0;
    eng_rd_buf = 2'h0;
    eng_rd_word = 2'h0;
  end
  // Frame takes 20 cycles so software can act while it is on the bus
  task send(input int b, input bit fail);
    if (tx_pending[b]) begin
      @(posedge aclk);
      tx_active[b] <= 1'b1;
      repeat (20) @(posedge aclk);
      if (fail) tx_fail[b] <= 1'b1;
      else tx_done[b] <= 1'b1;
      tx_active[b] <= 1'b0;
      @(posedge aclk);
      tx_fail[b] <= 1'b0;
      tx_done[b] <= 1'b0;
    end
  endtask
  // Index is only valid with its strobe; afterwards show the inverse
  task rx(input [2:0] idx);
    @(posedge aclk);
    rx_shift <= 1'b1;
    rx_hit_index <= idx;
    @(posedge aclk);
    rx_shift <= 1'b0;
    rx_hit_index <= ~idx;
  endtask
endmodule // cbf_eng_model

// ==== cbf_lowbit.v ====
// Lowest-set-bit picker for the transmit buffer selection
`timescale 1ns/1ps
module cbf_lowbit #(
  parameter N = 3
) (
  input  wire [N-1:0] vec,
  output reg  [N-1:0] onehot,
  output reg  [1:0]   index,
  output wire         any
);
  integer i;

  assign any = |vec;

  always @* begin
    onehot = {N{1'b0}};
    index  = 2'h0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (vec[i]) begin
        onehot    = {N{1'b0}};
        onehot[i] = 1'b1;
        index     = i[1:0];
      end
    end
  end
endmodule // cbf_lowbit
